// ===== design/rsa_pkg.sv
// Package: register map, field layout, timing and types of the rail strobe assignment block
package rsa_pkg;

	// ----------------------------------------------------------------
	// Register subaddresses and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RSA_ADDR_BB_B3   = 8'h23;
	localparam logic [7:0] RSA_ADDR_BACKUP  = 8'h24;
	localparam logic [7:0] RSA_ADDR_SW_LDO  = 8'h25;
	localparam logic [7:0] RSA_RST_BB_B3    = 8'h37;
	localparam logic [7:0] RSA_RST_BACKUP   = 8'h00;
	localparam logic [7:0] RSA_RST_SW_LDO   = 8'hA8;
	// Writable bits of the backup register; the rest are reserved
	localparam logic [7:0] RSA_BACKUP_MASK  = 8'h33;
	localparam logic [7:0] RSA_READ_ZERO    = 8'h00;

	// ----------------------------------------------------------------
	// Field positions and strobe codes
	// ----------------------------------------------------------------
	localparam int RSA_HI_NIB_LSB = 4;
	localparam int RSA_B6_LSB     = 4;
	localparam int RSA_B5_LSB     = 0;
	localparam logic [3:0] RSA_STROBE_FIRST  = 4'h1;
	localparam logic [3:0] RSA_STROBE_SEALED = 4'h3;
	localparam logic [3:0] RSA_STROBE_LAST   = 4'hA;
	localparam logic [3:0] RSA_CODE4_MIN     = 4'h3;
	localparam logic [3:0] RSA_CODE4_MAX     = 4'hA;
	localparam logic [1:0] RSA_CODE2_S1      = 2'h1;
	localparam logic [1:0] RSA_CODE2_S2      = 2'h2;

	// Rail numbering inside the enable vector
	localparam int RSA_NUM_RAILS = 6;
	localparam int RSA_NUM_FULL  = 4;
	localparam int RSA_RAIL_B3   = 0;
	localparam int RSA_RAIL_BB   = 1;
	localparam int RSA_RAIL_LDO  = 2;
	localparam int RSA_RAIL_SW   = 3;
	localparam int RSA_RAIL_B5   = 4;
	localparam int RSA_RAIL_B6   = 5;
	localparam int RSA_NUM_GAPS  = 9;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int RSA_CLK_HZ       = 100_000_000;
	localparam int RSA_GAP_SHORT_MS = 2;
	localparam int RSA_GAP_LONG_MS  = 5;
	localparam int RSA_GAP_SHORT_CYC = RSA_GAP_SHORT_MS * (RSA_CLK_HZ / 1000);
	localparam int RSA_GAP_LONG_CYC  = RSA_GAP_LONG_MS * (RSA_CLK_HZ / 1000);
	localparam int RSA_CNT_W         = 20;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rsa_reg_req_t;

	typedef enum logic [1:0] {
		RSA_IDLE,
		RSA_UP_GAP,
		RSA_DOWN_GAP
	} rsa_state_t;

endpackage

// ===== design/rsa_strobe_assign.sv
// Rail strobe assignment: strobe registers, strobe stepper and rail enables
//
// Overview of operation
// - Codes 3h..Ah enable rail at that strobe
// - Other 4-bit codes leave rail uncontrolled
// - Backup codes: 1h strobe1, 2h strobe2, else none
// - Strobes 1 and 2 only while seal intact
// - Broken seal: backup bucks never switched off
// - Backup register 0x24, reset 00h, fields 5-4/1-0
// - Switch/linear register 0x25, reset A8h
// - Buck-boost 7-4 reset 3h, buck3 3-0 reset 7h
// - Gap delay 2 ms or 5 ms per bit
`timescale 1ns/1ps
module rsa_strobe_assign #(
	parameter int SHORT_CYCLES = rsa_pkg::RSA_GAP_SHORT_CYC,
	parameter int LONG_CYCLES  = rsa_pkg::RSA_GAP_LONG_CYC
) (
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire rsa_pkg::rsa_reg_req_t        reg_req,
	output logic [7:0]                        reg_rd_data,
	output logic                              reg_rd_valid,
	input  wire logic                         unlock_ok,
	input  wire logic                         freshness_seal_flag,
	input  wire logic [rsa_pkg::RSA_NUM_GAPS-1:0] gap_delay_select,
	input  wire logic                         power_up_req,
	input  wire logic                         power_down_req,
	output logic [3:0]                        strobe_index,
	output logic                              strobe_fire,
	output logic                              seq_busy,
	output logic [rsa_pkg::RSA_NUM_RAILS-1:0] rail_enable
);
	import rsa_pkg::*;

	// ----------------------------------------------------------------
	// Strobe registers
	// ----------------------------------------------------------------
	logic [7:0] bb_b3_reg, bb_b3_next;
	logic [7:0] backup_reg, backup_next;
	logic [7:0] sw_ldo_reg, sw_ldo_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic       rd_valid_reg, rd_valid_next;
	logic       wr_ok;

	// Writes land only after unlock; reserved backup bits masked off
	always_comb begin
		wr_ok         = reg_req.wr && unlock_ok;
		bb_b3_next    = bb_b3_reg;
		backup_next   = backup_reg;
		sw_ldo_next   = sw_ldo_reg;
		rd_valid_next = reg_req.rd;
		rd_data_next  = rd_data_reg;
		if (wr_ok) begin
			case (reg_req.addr)
				RSA_ADDR_BB_B3:  bb_b3_next  = reg_req.wdata;
				RSA_ADDR_BACKUP: backup_next = reg_req.wdata & RSA_BACKUP_MASK;
				RSA_ADDR_SW_LDO: sw_ldo_next = reg_req.wdata;
				default:         bb_b3_next  = bb_b3_reg;
			endcase
		end
		if (reg_req.rd) begin
			case (reg_req.addr)
				RSA_ADDR_BB_B3:  rd_data_next = bb_b3_reg;
				RSA_ADDR_BACKUP: rd_data_next = backup_reg & RSA_BACKUP_MASK;
				RSA_ADDR_SW_LDO: rd_data_next = sw_ldo_reg;
				default:         rd_data_next = RSA_READ_ZERO;
			endcase
		end
	end

	// Register state; reset values are the documented defaults
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bb_b3_reg    <= RSA_RST_BB_B3;
			backup_reg   <= RSA_RST_BACKUP;
			sw_ldo_reg   <= RSA_RST_SW_LDO;
			rd_data_reg  <= RSA_READ_ZERO;
			rd_valid_reg <= 1'b0;
		end else begin
			bb_b3_reg    <= bb_b3_next;
			backup_reg   <= backup_next;
			sw_ldo_reg   <= sw_ldo_next;
			rd_data_reg  <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign reg_rd_data  = rd_data_reg;
	assign reg_rd_valid = rd_valid_reg;

	// ----------------------------------------------------------------
	// Strobe stepper
	// ----------------------------------------------------------------
	rsa_state_t           state_reg, state_next;
	logic [3:0]           idx_reg, idx_next;
	logic                 fire_reg, fire_next;
	logic                 up_reg, up_next;
	logic [RSA_CNT_W-1:0] cnt_reg, cnt_next;
	logic [RSA_CNT_W-1:0] target;
	logic [3:0]           gap_no;
	logic [3:0]           low_strobe;

	// Parts with the seal broken start and end at strobe 3, skipping the backup strobes
	always_comb begin
		low_strobe = freshness_seal_flag ? RSA_STROBE_SEALED : RSA_STROBE_FIRST;
		gap_no     = up_reg ? 4'(idx_reg - 4'h1) : 4'(idx_reg - 4'h2);
		target     = gap_delay_select[gap_no] ? RSA_CNT_W'(LONG_CYCLES)
		                                      : RSA_CNT_W'(SHORT_CYCLES);
		state_next = state_reg;
		idx_next   = idx_reg;
		up_next    = up_reg;
		cnt_next   = cnt_reg;
		fire_next  = 1'b0;
		case (state_reg)
			RSA_IDLE: begin
				cnt_next = '0;
				if (power_up_req) begin
					idx_next   = low_strobe;
					up_next    = 1'b1;
					fire_next  = 1'b1;
					state_next = RSA_UP_GAP;
				end else if (power_down_req) begin
					idx_next   = RSA_STROBE_LAST;
					up_next    = 1'b0;
					fire_next  = 1'b1;
					state_next = RSA_DOWN_GAP;
				end
			end
			RSA_UP_GAP, RSA_DOWN_GAP: begin
				if (cnt_reg == target - RSA_CNT_W'(1)) begin
					cnt_next  = '0;
					fire_next = 1'b1;
					idx_next  = up_reg ? 4'(idx_reg + 4'h1) : 4'(idx_reg - 4'h1);
					if (up_reg ? (idx_next == RSA_STROBE_LAST) : (idx_next == low_strobe))
						state_next = RSA_IDLE;
				end else begin
					cnt_next = RSA_CNT_W'(cnt_reg + RSA_CNT_W'(1));
				end
			end
			default: state_next = RSA_IDLE;
		endcase
	end

	// Stepper registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= RSA_IDLE;
			idx_reg   <= '0;
			fire_reg  <= 1'b0;
			up_reg    <= 1'b0;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			fire_reg  <= fire_next;
			up_reg    <= up_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign strobe_index = idx_reg;
	assign strobe_fire  = fire_reg;
	assign seq_busy     = (state_reg != RSA_IDLE);

	// ----------------------------------------------------------------
	// Rail enables, one decoder per rail
	// ----------------------------------------------------------------
	logic [3:0]               code [RSA_NUM_RAILS];
	logic [RSA_NUM_RAILS-1:0] hit;
	logic [RSA_NUM_RAILS-1:0] en_reg, en_next;

	assign code[RSA_RAIL_B3]  = bb_b3_reg[3:0];
	assign code[RSA_RAIL_BB]  = bb_b3_reg[RSA_HI_NIB_LSB +: 4];
	assign code[RSA_RAIL_LDO] = sw_ldo_reg[3:0];
	assign code[RSA_RAIL_SW]  = sw_ldo_reg[RSA_HI_NIB_LSB +: 4];
	assign code[RSA_RAIL_B5]  = {2'b00, backup_reg[RSA_B5_LSB +: 2]};
	assign code[RSA_RAIL_B6]  = {2'b00, backup_reg[RSA_B6_LSB +: 2]};

	// Decoding from registered strobe keeps the enables glitch free
	genvar g;
	generate
		for (g = 0; g < RSA_NUM_RAILS; g++) begin : g_rail
			if (g < RSA_NUM_FULL) begin : g_full
				assign hit[g] = code[g] >= RSA_CODE4_MIN && code[g] <= RSA_CODE4_MAX
				                && code[g] == idx_reg;
			end else begin : g_backup
				assign hit[g] = (code[g][1:0] == RSA_CODE2_S1 && idx_reg == 4'h1)
				             || (code[g][1:0] == RSA_CODE2_S2 && idx_reg == 4'h2);
			end
			always_comb begin
				en_next[g] = en_reg[g];
				if (fire_reg && hit[g]) begin
					if (up_reg)
						en_next[g] = 1'b1;
					else if (!(g >= RSA_NUM_FULL && freshness_seal_flag))
						en_next[g] = 1'b0;
				end
			end
		end
	endgenerate

	// Enable vector
	always_ff @(posedge sys_clk) begin
		if (rst)
			en_reg <= '0;
		else
			en_reg <= en_next;
	end

	assign rail_enable = en_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_code4_enable;
		@(posedge sys_clk) disable iff (rst)
		(fire_reg && up_reg && bb_b3_reg[3:0] == idx_reg && idx_reg >= RSA_CODE4_MIN)
		|=> en_reg[RSA_RAIL_B3];
	endproperty
	a_code4_enable: assert property (p_code4_enable) else $error("buck3 not enabled at strobe");

	property p_code4_idle;
		@(posedge sys_clk) disable iff (rst)
		(bb_b3_reg[RSA_HI_NIB_LSB +: 4] > RSA_CODE4_MAX
		 || bb_b3_reg[RSA_HI_NIB_LSB +: 4] < RSA_CODE4_MIN)
		|=> $stable(en_reg[RSA_RAIL_BB]);
	endproperty
	a_code4_idle: assert property (p_code4_idle) else $error("uncontrolled rail changed");

	property p_backup_strobe;
		@(posedge sys_clk) disable iff (rst)
		(fire_reg && up_reg && idx_reg == 4'h2 && backup_reg[RSA_B6_LSB +: 2] == RSA_CODE2_S2)
		|=> en_reg[RSA_RAIL_B6];
	endproperty
	a_backup_strobe: assert property (p_backup_strobe) else $error("buck6 missed strobe 2");

	property p_seal_skip;
		@(posedge sys_clk) disable iff (rst)
		(freshness_seal_flag && fire_reg) |-> idx_reg >= RSA_STROBE_SEALED;
	endproperty
	a_seal_skip: assert property (p_seal_skip) else $error("strobe 1 or 2 with seal broken");

	property p_backup_kept;
		@(posedge sys_clk) disable iff (rst)
		(freshness_seal_flag && en_reg[RSA_RAIL_B5]) |=> en_reg[RSA_RAIL_B5];
	endproperty
	a_backup_kept: assert property (p_backup_kept) else $error("backup buck switched off");

	property p_reserved_zero;
		@(posedge sys_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == RSA_ADDR_BACKUP)
		|=> rd_valid_reg && (rd_data_reg & ~RSA_BACKUP_MASK) == RSA_READ_ZERO;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	// Checked one edge after a reset edge, so registers are never still unset
	property p_reset_values;
		@(posedge sys_clk)
		rst |=> sw_ldo_reg == RSA_RST_SW_LDO && bb_b3_reg == RSA_RST_BB_B3
		        && backup_reg == RSA_RST_BACKUP;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("bad strobe reset value");

	property p_gap_end;
		@(posedge sys_clk) disable iff (rst)
		(state_reg != RSA_IDLE && cnt_reg == target - RSA_CNT_W'(1)) |=> fire_reg ##1 !fire_reg;
	endproperty
	a_gap_end: assert property (p_gap_end) else $error("strobe not fired at gap end");

	property p_locked;
		@(posedge sys_clk) disable iff (rst)
		(reg_req.wr && !unlock_ok) |=> $stable(sw_ldo_reg) && $stable(backup_reg);
	endproperty
	a_locked: assert property (p_locked) else $error("locked write took effect");

endmodule // rsa_strobe_assign

// ===== dv/rsa_host_model.sv
// Host model: single-byte register writes and reads over the strobe port
`timescale 1ns/1ps
module rsa_host_model (
	input  wire logic             sys_clk,
	output rsa_pkg::rsa_reg_req_t reg_req,
	input  wire logic [7:0]       reg_rd_data,
	input  wire logic             reg_rd_valid
);
	import rsa_pkg::*;

	initial reg_req = '{addr: 8'hFF, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};

	// One-cycle write; released lines show inverted values, not stale ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge sys_clk);
		reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask

	// One-cycle read; valid must follow one cycle after the strobe, else data is unknown
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		int n;
		n = 0;
		@(negedge sys_clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge sys_clk);
		reg_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
		while (reg_rd_valid !== 1'b1 && n < 4) begin
			@(negedge sys_clk);
			n++;
		end
		q = (n == 0) ? reg_rd_data : 8'hxx;
	endtask
endmodule // rsa_host_model

// ===== dv/tb_top.sv
// Testbench: register map, strobe walks, gap timing and seal behaviour
`timescale 1ns/1ps
module tb_top;
	import rsa_pkg::*;
	localparam int SH = 4;
	localparam int LG = 9;
	logic                     sys_clk = 0, rst = 1, unlock_ok = 0, freshness_seal_flag = 0;
	logic                     power_up_req = 0, power_down_req = 0;
	logic [RSA_NUM_GAPS-1:0]  gap_delay_select = '0;
	rsa_reg_req_t             reg_req;
	logic [7:0]               reg_rd_data, rd_q, bb, sw, bk;
	logic                     reg_rd_valid, strobe_fire, seq_busy;
	logic [3:0]               strobe_index;
	logic [RSA_NUM_RAILS-1:0] rail_enable, exp_rails = '0;
	int                       n_fail = 0, samples_checked = 0, seed = 98369, cyc = 0;

	always #5 sys_clk = ~sys_clk;

	rsa_strobe_assign #(.SHORT_CYCLES(SH), .LONG_CYCLES(LG)) u_rsa_strobe_assign (
		.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
		.reg_rd_valid(reg_rd_valid), .unlock_ok(unlock_ok),
		.freshness_seal_flag(freshness_seal_flag), .gap_delay_select(gap_delay_select),
		.power_up_req(power_up_req), .power_down_req(power_down_req),
		.strobe_index(strobe_index), .strobe_fire(strobe_fire), .seq_busy(seq_busy),
		.rail_enable(rail_enable));
	rsa_host_model u_rsa_host_model (.sys_clk(sys_clk), .reg_req(reg_req),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Rails whose code names strobe s; 4-bit codes below 3 never hit
	function automatic logic [5:0] hits(input int s);
		logic [3:0] n;
		n = 4'(s);
		hits = {bk[5:4] == n[1:0] && s < 3, bk[1:0] == n[1:0] && s < 3,
			sw[7:4] == n && s > 2, sw[3:0] == n && s > 2,
			bb[7:4] == n && s > 2, bb[3:0] == n && s > 2};
	endfunction

	// One full walk, checking each strobe number and each gap length
	task automatic walk(input logic up);
		int s, p, g;
		s = up ? (freshness_seal_flag ? 3 : 1) : 10;
		p = s;
		if (up) power_up_req = 1'b1;
		else power_down_req = 1'b1;
		@(negedge sys_clk);
		power_up_req = 1'b0;
		power_down_req = 1'b0;
		g = 1;
		for (int i = 0; i < 10; i++) begin
			while (strobe_fire !== 1'b1 && g < 20) begin
				@(negedge sys_clk);
				g++;
			end
			if (i > 0) chk("gap", 8'(gap_delay_select[(up ? p : s) - 1] ? LG : SH), 8'(g));
			if (i == 0) chk("busy_walk", 8'h01, 8'(seq_busy));
			chk("index", 8'(s), 8'(strobe_index));
			exp_rails = up ? exp_rails | hits(s) : exp_rails & ~hits(s);
			if (s == (up ? 10 : (freshness_seal_flag ? 3 : 1))) break;
			p = s;
			s = up ? s + 1 : s - 1;
			@(negedge sys_clk);
			g = 1;
		end
		repeat (2) @(negedge sys_clk);
		chk("busy", 8'h00, 8'(seq_busy));
	endtask

	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict;
		end
	end

	initial begin
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		u_rsa_host_model.rd(RSA_ADDR_BB_B3, rd_q);
		chk("reg23", 8'h37, rd_q);
		u_rsa_host_model.rd(RSA_ADDR_BACKUP, rd_q);
		chk("reg24", 8'h00, rd_q);
		u_rsa_host_model.wr(RSA_ADDR_SW_LDO, 8'h53);
		u_rsa_host_model.rd(RSA_ADDR_SW_LDO, rd_q);
		chk("reg25", 8'hA8, rd_q);
		unlock_ok = 1'b1;
		u_rsa_host_model.rd(8'h30, rd_q);
		chk("unmapped", 8'h00, rd_q);
		for (int r = 0; r < 6; r++) begin
			bb = 8'($random(seed));
			sw = 8'($random(seed));
			bk = 8'($random(seed));
			if (r == 1) begin
				bb = 8'h2B;
				sw = 8'hA3;
				bk = 8'hED;
			end
			gap_delay_select = 9'($random(seed));
			freshness_seal_flag = (r >= 4);
			u_rsa_host_model.wr(RSA_ADDR_BB_B3, bb);
			u_rsa_host_model.wr(RSA_ADDR_BACKUP, bk);
			u_rsa_host_model.wr(RSA_ADDR_SW_LDO, sw);
			bk = bk & 8'h33;
			u_rsa_host_model.rd(RSA_ADDR_BACKUP, rd_q);
			chk("backup", bk, rd_q);
			walk(1'b1);
			chk("rails_up", 8'(exp_rails), 8'(rail_enable));
			freshness_seal_flag = (r % 2 == 1 || r >= 4);
			walk(1'b0);
			chk("rails_down", 8'(exp_rails), 8'(rail_enable));
		end
		print_verdict;
	end
endmodule // tb_top
